// file: logic/pll_and_power_mode_control.sv
// pll reference, lock status and power mode control registers
//
// Design decision made here: strobed register access.
`timescale 1ns/10ps
`default_nettype none
module pll_and_power_mode_control (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // register port
  input wire logic [31:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  // pins and analog status
  input wire logic crystal_input_pin,
  input wire logic pll_locked,
  input wire logic wake_event,
  // neighbouring logic on this clock
  input wire logic high_voltage_config,
  input wire logic wake_timer_on_lp,
  // clock controls
  output logic [1:0] pll_ref_sel,
  output logic [9:0] pll_mult,
  output logic [2:0] core_divider,
  output logic core_clk_en,
  output logic flash_clk_en,
  // power controls
  output logic precision_osc_en,
  output logic crystal_en,
  output logic pll_en,
  output logic periph_en,
  output logic core_en,
  output logic lin_wake_en,
  output logic wake_timer_run
);
  // ==========================================================
  // synchronisers for pins from other domains
  logic xtal_meta;
  logic xtal_s;
  logic lock_meta;
  logic lock_s;
  logic lock_d;
  logic wake_meta;
  logic wake_s;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      xtal_meta <= 1'b0;
      xtal_s <= 1'b0;
      lock_meta <= 1'b0;
      lock_s <= 1'b0;
      lock_d <= 1'b0;
      wake_meta <= 1'b0;
      wake_s <= 1'b0;
    end else begin
      xtal_meta <= crystal_input_pin;
      xtal_s <= xtal_meta;
      lock_meta <= pll_locked;
      lock_s <= lock_meta;
      lock_d <= lock_s;
      wake_meta <= wake_event;
      wake_s <= wake_meta;
    end
  end

  // ==========================================================
  // key sequencers
  key_write_if pll_bus ();
  key_write_if pow_bus ();

  assign pll_bus.wr = wr;
  assign pll_bus.addr = addr;
  assign pll_bus.wdata = wdata;
  assign pow_bus.wr = wr;
  assign pow_bus.addr = addr;
  assign pow_bus.wdata = wdata;

  key_write_gate #(
    .PRE_ADDR(pll_power_pkg::ADDR_PLL_PRE),
    .REG_ADDR(pll_power_pkg::ADDR_PLL_SRC),
    .POST_ADDR(pll_power_pkg::ADDR_PLL_POST),
    .PRE_KEY(pll_power_pkg::PLL_PRE_KEY),
    .POST_KEY(pll_power_pkg::PLL_POST_KEY)
  ) pll_gate (
    .mclk(mclk),
    .rst_n(rst_n),
    .bus(pll_bus.gate)
  );

  key_write_gate #(
    .PRE_ADDR(pll_power_pkg::ADDR_POW_PRE),
    .REG_ADDR(pll_power_pkg::ADDR_POWER),
    .POST_ADDR(pll_power_pkg::ADDR_POW_POST),
    .PRE_KEY(pll_power_pkg::POW_PRE_KEY),
    .POST_KEY(pll_power_pkg::POW_POST_KEY)
  ) pow_gate (
    .mclk(mclk),
    .rst_n(rst_n),
    .bus(pow_bus.gate)
  );

  // ==========================================================
  // pll source select
  logic [1:0] pll_source_select;
  wire [1:0] new_src = pll_bus.data[1:0];
  // the reserved code is refused so the pll never loses its reference
  wire src_ok = new_src != pll_power_pkg::SRC_RESERVED;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pll_source_select <= pll_power_pkg::PLL_SRC_RESET;
    end else if (pll_bus.commit && src_ok) begin
      pll_source_select <= new_src;
    end
  end

  // ==========================================================
  // power control with interlocks and wake-up
  logic [7:0] power_control;
  logic [7:0] next_power;
  wire [7:0] cand = pow_bus.data;
  wire cand_core = cand[pll_power_pkg::PWR_CORE_BIT];
  wire cand_periph = cand[pll_power_pkg::PWR_PERIPH_BIT] | cand_core;
  wire cand_pll = cand[pll_power_pkg::PWR_PLL_BIT] | cand_periph;

  always_comb begin
    next_power = power_control;
    if (pow_bus.commit) begin
      next_power = cand;
      next_power[pll_power_pkg::PWR_PERIPH_BIT] = cand_periph;
      next_power[pll_power_pkg::PWR_PLL_BIT] = cand_pll;
    end
    // wake-up wins over a power-down arriving in the same cycle
    if (wake_s) begin
      next_power[pll_power_pkg::PWR_PLL_BIT] = 1'b1;
      next_power[pll_power_pkg::PWR_PERIPH_BIT] = 1'b1;
      next_power[pll_power_pkg::PWR_CORE_BIT] = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      power_control <= pll_power_pkg::POWER_RESET;
    end else begin
      power_control <= next_power;
    end
  end

  // ==========================================================
  // lock loss flag
  logic lock_lost;
  wire lock_fall = lock_d && !lock_s;
  wire stat_wr = wr && addr == pll_power_pkg::ADDR_STATUS;
  wire lost_clr = stat_wr && wdata[pll_power_pkg::STAT_LOST_BIT];

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      lock_lost <= 1'b0;
    end else if (lock_fall) begin
      lock_lost <= 1'b1;
    end else if (lost_clr) begin
      lock_lost <= 1'b0;
    end
  end

  // ==========================================================
  // clock enables; mclk stands for the pll output
  logic [pll_power_pkg::DIV_W-1:0] div_count;
  wire [2:0] cd = power_control[pll_power_pkg::CD_MSB:pll_power_pkg::CD_LSB];
  wire [pll_power_pkg::DIV_W-1:0] cd_mask =
    ~({pll_power_pkg::DIV_W{1'b1}} << cd);
  wire core_tick = &(div_count | ~cd_mask);
  wire flash_tick = &div_count[pll_power_pkg::FLASH_DIV_LOG2-1:0];
  wire pll_on = power_control[pll_power_pkg::PWR_PLL_BIT];

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      div_count <= '0;
      core_clk_en <= 1'b0;
      flash_clk_en <= 1'b0;
    end else begin
      div_count <= div_count + 1'b1;
      core_clk_en <= pll_on && core_en && core_tick;
      // fallback rate keeps flash timing safe while lock is acquired
      flash_clk_en <= pll_on && periph_en && (lock_s || flash_tick);
    end
  end

  // ==========================================================
  // registered controls
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pll_ref_sel <= pll_power_pkg::SRC_LOW_POWER;
      pll_mult <= 10'h000;
      precision_osc_en <= 1'b0;
      lin_wake_en <= 1'b0;
      wake_timer_run <= 1'b0;
    end else begin
      pll_ref_sel <= pll_source_select;
      pll_mult <= pll_power_pkg::PLL_MULT;
      precision_osc_en <= power_control[pll_power_pkg::PWR_PREC_BIT] &&
        high_voltage_config;
      // lin wake detection is not gated by the peripheral bit
      lin_wake_en <= 1'b1;
      wake_timer_run <= wake_timer_on_lp || periph_en;
    end
  end

  assign crystal_en = power_control[pll_power_pkg::PWR_XTAL_BIT];
  assign pll_en = power_control[pll_power_pkg::PWR_PLL_BIT];
  assign periph_en = power_control[pll_power_pkg::PWR_PERIPH_BIT];
  assign core_en = power_control[pll_power_pkg::PWR_CORE_BIT];
  assign core_divider = cd;

  // ==========================================================
  // read port, data one cycle after the strobe
  wire [7:0] status_val = {5'h00, xtal_s, lock_s, lock_lost};
  wire hit_stat = addr == pll_power_pkg::ADDR_STATUS;
  wire hit_pow = addr == pll_power_pkg::ADDR_POWER;
  wire hit_src = addr == pll_power_pkg::ADDR_PLL_SRC;
  wire [7:0] read_val = hit_stat ? status_val :
    hit_pow ? power_control :
    hit_src ? {6'h00, pll_source_select} : 8'h00;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 32'h00000000;
    end else if (rd) begin
      rdata <= {24'h000000, read_val};
    end else begin
      rdata <= 32'h00000000;
    end
  end
endmodule
`default_nettype wire

// file: pkg/pll_power_pkg.sv
// constants and types for the pll and power mode control block
package pll_power_pkg;
  // ==========================================================
  // register byte addresses
  localparam logic [31:0] ADDR_STATUS = 32'hffff0400;
  localparam logic [31:0] ADDR_POW_PRE = 32'hffff0404;
  localparam logic [31:0] ADDR_POWER = 32'hffff0408;
  localparam logic [31:0] ADDR_POW_POST = 32'hffff040c;
  localparam logic [31:0] ADDR_PLL_PRE = 32'hffff0410;
  localparam logic [31:0] ADDR_PLL_SRC = 32'hffff0414;
  localparam logic [31:0] ADDR_PLL_POST = 32'hffff0418;
  // ==========================================================
  // key values
  localparam logic [31:0] PLL_PRE_KEY = 32'h000000aa;
  localparam logic [31:0] PLL_POST_KEY = 32'h00000055;
  localparam logic [31:0] POW_PRE_KEY = 32'h00000001;
  localparam logic [31:0] POW_POST_KEY = 32'h000000f4;
  // ==========================================================
  // reset values
  localparam logic [7:0] POWER_RESET = 8'h79;
  localparam logic [1:0] PLL_SRC_RESET = 2'h0;
  // ==========================================================
  // status fields
  localparam int STAT_LOST_BIT = 0;
  localparam int STAT_LOCK_BIT = 1;
  localparam int STAT_XTAL_BIT = 2;
  // ==========================================================
  // power control fields
  localparam int PWR_PREC_BIT = 7;
  localparam int PWR_XTAL_BIT = 6;
  localparam int PWR_PLL_BIT = 5;
  localparam int PWR_PERIPH_BIT = 4;
  localparam int PWR_CORE_BIT = 3;
  localparam int CD_MSB = 2;
  localparam int CD_LSB = 0;
  // ==========================================================
  // reference source codes
  localparam logic [1:0] SRC_LOW_POWER = 2'h0;
  localparam logic [1:0] SRC_PRECISION = 2'h1;
  localparam logic [1:0] SRC_CRYSTAL = 2'h2;
  localparam logic [1:0] SRC_RESERVED = 2'h3;
  // ==========================================================
  // pll and divider figures
  localparam logic [9:0] PLL_MULT = 10'h271;
  localparam int FLASH_DIV_LOG2 = 3;
  localparam int DIV_W = 7;
  // ==========================================================
  // key sequencer states
  typedef enum logic [1:0] {key_idle, key_armed, key_loaded} key_state_e;
endpackage

// file: pkg/key_write_if.sv
// bus tap and commit result between the top and a key sequencer
`timescale 1ns/10ps
`default_nettype none
interface key_write_if;
  logic wr;
  logic [31:0] addr;
  logic [31:0] wdata;
  logic commit;
  logic [7:0] data;
  modport gate (input wr, input addr, input wdata,
    output commit, output data);
  modport host (output wr, output addr, output wdata,
    input commit, input data);
endinterface
`default_nettype wire

// file: logic/key_write_gate.sv
// key sequencer guarding one protected register
`timescale 1ns/10ps
`default_nettype none
module key_write_gate #(
  parameter logic [31:0] PRE_ADDR = 32'h0,
  parameter logic [31:0] REG_ADDR = 32'h4,
  parameter logic [31:0] POST_ADDR = 32'h8,
  parameter logic [31:0] PRE_KEY = 32'h1,
  parameter logic [31:0] POST_KEY = 32'h2
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // bus tap and commit
  key_write_if.gate bus
);
  pll_power_pkg::key_state_e state;
  pll_power_pkg::key_state_e next_state;
  logic [7:0] held;
  wire pre_ok = bus.wr && bus.addr == PRE_ADDR && bus.wdata == PRE_KEY;
  wire reg_hit = bus.wr && bus.addr == REG_ADDR;
  wire post_ok = bus.wr && bus.addr == POST_ADDR && bus.wdata == POST_KEY;
  wire fire = post_ok && state == pll_power_pkg::key_loaded;

  // ==========================================================
  // sequence: pre key, value, post key, as consecutive writes
  always_comb begin
    next_state = state;
    if (bus.wr) begin
      next_state = pll_power_pkg::key_idle;
      unique case (state)
        pll_power_pkg::key_idle: ;
        pll_power_pkg::key_armed: begin
          if (reg_hit) begin
            next_state = pll_power_pkg::key_loaded;
          end
        end
        pll_power_pkg::key_loaded: ;
      endcase
      // a fresh pre key always restarts the sequence
      if (pre_ok) begin
        next_state = pll_power_pkg::key_armed;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state <= pll_power_pkg::key_idle;
      held <= 8'h00;
      bus.commit <= 1'b0;
      bus.data <= 8'h00;
    end else begin
      state <= next_state;
      if (reg_hit && state == pll_power_pkg::key_armed) begin
        held <= bus.wdata[7:0];
      end
      bus.commit <= fire;
      bus.data <= held;
    end
  end
endmodule
`default_nettype wire

// file: sim/pll_and_power_mode_control_monitor.sv
// assertion checker for the pll and power mode control block
`timescale 1ns/10ps
`default_nettype none
module pll_and_power_mode_control_monitor (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // register port
  input wire logic [31:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [31:0] rdata,
  // pins
  input wire logic crystal_input_pin,
  input wire logic pll_locked,
  input wire logic wake_event,
  input wire logic high_voltage_config,
  input wire logic wake_timer_on_lp,
  // controls
  input wire logic [1:0] pll_ref_sel,
  input wire logic [9:0] pll_mult,
  input wire logic [2:0] core_divider,
  input wire logic core_clk_en,
  input wire logic flash_clk_en,
  input wire logic precision_osc_en,
  input wire logic crystal_en,
  input wire logic pll_en,
  input wire logic periph_en,
  input wire logic core_en,
  input wire logic lin_wake_en,
  input wire logic wake_timer_run
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // ==========================================================
  // status and controls
  // four samples cover the two-stage pin synchroniser
  property p_xtal;
    crystal_input_pin [*4] ##0 (rd && addr == 32'hffff0400) |=> rdata[2];
  endproperty
  a_xtal: assert property (p_xtal) else $error("crystal bit wrong");
  property p_lost;
    pll_locked ##1 !pll_locked [*4] ##0 (rd && addr == 32'hffff0400)
      |=> rdata[0] && !rdata[1];
  endproperty
  a_lost: assert property (p_lost)
    else $error("lock loss missed");
  property p_src;
    pll_ref_sel != 2'h3;
  endproperty
  a_src: assert property (p_src) else $error("reserved source");
  property p_chain;
    (core_en |-> periph_en) and (periph_en |-> pll_en);
  endproperty
  a_chain: assert property (p_chain)
    else $error("interlock broken");
  property p_wake;
    wake_event [*4] |-> ##[0:3] (core_en && periph_en && pll_en);
  endproperty
  a_wake: assert property (p_wake)
    else $error("wake ignored");
  property p_prec;
    !high_voltage_config |=> !precision_osc_en;
  endproperty
  a_prec: assert property (p_prec) else $error("precision on");
  // the divider must already be one when the pulse was launched
  property p_div;
    (core_divider == 3'h1) ##1 (core_clk_en && core_divider == 3'h1)
      |=> !core_clk_en;
  endproperty
  a_div: assert property (p_div) else $error("divide by two");
  property p_flash;
    (!pll_locked && pll_en && periph_en) [*4] ##0 flash_clk_en
      |=> !flash_clk_en;
  endproperty
  a_flash: assert property (p_flash) else $error("flash rate");
  property p_timer;
    wake_timer_on_lp |=> wake_timer_run;
  endproperty
  a_timer: assert property (p_timer) else $error("timer stopped");
  property p_mult;
    $past(rst_n) |-> lin_wake_en && pll_mult == 10'h271;
  endproperty
  a_mult: assert property (p_mult) else $error("multiplier");
endmodule
bind pll_and_power_mode_control pll_and_power_mode_control_monitor u_mon (
  .mclk, .rst_n, .addr, .wdata, .wr, .rd, .rdata, .crystal_input_pin,
  .pll_locked, .wake_event, .high_voltage_config, .wake_timer_on_lp,
  .pll_ref_sel, .pll_mult, .core_divider, .core_clk_en, .flash_clk_en,
  .precision_osc_en, .crystal_en, .pll_en, .periph_en, .core_en,
  .lin_wake_en, .wake_timer_run);
`default_nettype wire

// file: sim/test_pll_and_power_mode_control.sv
// self-checking testbench for the pll and power mode control block
`timescale 1ns/10ps
`default_nettype none
module test_pll_and_power_mode_control;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [31:0] addr = 32'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic crystal_input_pin = 1'b0;
  logic pll_locked = 1'b1;
  logic wake_event = 1'b0;
  logic high_voltage_config = 1'b0;
  logic wake_timer_on_lp = 1'b0;
  logic [31:0] rdata;
  logic [1:0] pll_ref_sel;
  logic [9:0] pll_mult;
  logic [2:0] core_divider;
  logic core_clk_en, flash_clk_en, precision_osc_en, crystal_en;
  logic pll_en, periph_en, core_en, lin_wake_en, wake_timer_run;
  int mismatches = 0;
  int n_checks = 0;
  logic [31:0] r = 32'h576f;
  logic [31:0] nc, nf;
  logic [7:0] pv;
  logic [1:0] ps = 2'h0;
  pll_and_power_mode_control u_dut (.mclk, .rst_n, .addr, .wdata, .wr,
    .rd, .rdata, .crystal_input_pin, .pll_locked, .wake_event,
    .high_voltage_config, .wake_timer_on_lp, .pll_ref_sel, .pll_mult,
    .core_divider, .core_clk_en, .flash_clk_en, .precision_osc_en,
    .crystal_en, .pll_en, .periph_en, .core_en, .lin_wake_en,
    .wake_timer_run);
  always #2.5 mclk = ~mclk;
  // ==========================================================
  // helpers
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // keep the interlock satisfied so the read-back is unambiguous
  function automatic logic [7:0] fix(input logic [7:0] v);
    return v | {2'h0, v[4] | v[3], v[3], 4'h0};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [31:0] a, d);
    @(posedge mclk);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= d;
    @(posedge mclk);
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic rchk(input logic [31:0] a, exp);
    bus(1'b0, a, 32'h0);
    #1;
    chk(rdata, exp);
  endtask
  // brk 1 slips a stray write in, brk 2 spoils the closing key
  task automatic keyed(input logic pw, input logic [7:0] v,
                       input logic [1:0] brk);
    bus(1'b1, pw ? 32'hffff0404 : 32'hffff0410, pw ? 32'h1 : 32'haa);
    if (brk == 2'h1) begin
      bus(1'b1, 32'hffff0500, 32'h0);
    end
    bus(1'b1, pw ? 32'hffff0408 : 32'hffff0414, {24'h0, v});
    bus(1'b1, pw ? 32'hffff040c : 32'hffff0418,
        (pw ? 32'hf4 : 32'h55) ^ {31'h0, brk[1]});
    // idle cycles after the change stand in for the dummy cycle
    repeat (3) @(posedge mclk);
  endtask
  task automatic count_en;
    nc = 32'h0;
    nf = 32'h0;
    repeat (128) begin
      @(posedge mclk);
      #1;
      nc += {31'h0, core_clk_en};
      nf += {31'h0, flash_clk_en};
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // ==========================================================
  // main sequence
  initial begin
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    rchk(32'hffff0408, 32'h79);
    rchk(32'hffff0414, 32'h0);
    rchk(32'hffff0404, 32'h0);
    rchk(32'hffff0500, 32'h0);
    rchk(32'hffff0400, 32'h2);
    for (int i = 0; i < 8; i++) begin
      r = lfsr(r);
      pv = fix({r[7:3], i[2:0]});
      @(posedge mclk);
      high_voltage_config <= r[8];
      wake_timer_on_lp <= r[9];
      keyed(1'b1, pv, 2'h0);
      rchk(32'hffff0408, {24'h0, pv});
      chk({precision_osc_en, crystal_en, pll_en},
          {pv[7] & r[8], pv[6:5]});
      chk({periph_en, core_en, core_divider}, pv[4:0]);
      chk(wake_timer_run, r[9] | pv[4]);
      count_en();
      chk(nc, pv[3] ? 32'h80 >> pv[2:0] : 32'h0);
      chk(nf, pv[4] ? 32'h80 : 32'h0);
      ps = (i[1:0] == 2'h3) ? ps : i[1:0];
      // reserved upper bits are always written as zero
      keyed(1'b0, {6'h00, i[1:0]}, 2'h0);
      rchk(32'hffff0414, {30'h0, ps});
      chk(pll_ref_sel, ps);
    end
    keyed(1'b1, 8'h08, 2'h0);
    chk({pll_en, periph_en, core_en}, 3'h7);
    keyed(1'b1, 8'h00, 2'h1);
    keyed(1'b1, 8'h00, 2'h2);
    keyed(1'b0, 8'h01, 2'h2);
    rchk(32'hffff0414, {30'h0, ps});
    rchk(32'hffff0408, 32'h38);
    keyed(1'b1, 8'h00, 2'h0);
    rchk(32'hffff0408, 32'h0);
    @(posedge mclk);
    wake_event <= 1'b1;
    repeat (4) @(posedge mclk);
    wake_event <= 1'b0;
    repeat (3) @(posedge mclk);
    rchk(32'hffff0408, 32'h38);
    // read lands on the fourth low sample of the lock input
    @(posedge mclk);
    pll_locked <= 1'b0;
    repeat (2) @(posedge mclk);
    rchk(32'hffff0400, 32'h1);
    count_en();
    chk(nf, 32'h10);
    chk(nc, 32'h80);
    bus(1'b1, 32'hffff0400, 32'h1);
    crystal_input_pin <= 1'b1;
    pll_locked <= 1'b1;
    repeat (4) @(posedge mclk);
    rchk(32'hffff0400, 32'h6);
    wrap_up();
  end
  initial begin
    repeat (100000) @(posedge mclk);
    mismatches++;
    wrap_up();
  end
endmodule
`default_nettype wire
